// file: core/clock_divider_and_pll_control.sv
// clock control: low-power divider, pll pre/post/feedback dividers, rtc tick, pfd, apb regs
// assumes oscTick and vcoTick are enable pulses on sys_clk; srst synchronous active high
`timescale 1ns/100ps
`include "clkgen_regs.svh"
module clock_divider_and_pll_control #(
  parameter int ADDR_W = 24,
  parameter int RTC_W = 32
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscTick,
  input wire logic vcoTick,
  input wire logic pllLockIn,
  input wire logic stopMode,
  output logic systemTick,
  output logic lowPowerTick,
  output logic refTick,
  output logic fbTick,
  output logic pllSysTick,
  output logic rtcTick,
  output logic pllEnable,
  output logic crystalMode,
  output logic lockLost,
  output logic pumpAdd,
  output logic pumpRemove,
  output logic [2:0] pumpStrength
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [3:0] lowPowerExp;
  logic [3:0] next_lowPowerExp;
  logic [2:0] predivField;
  logic [2:0] next_predivField;
  logic [2:0] activePrediv;
  logic [2:0] next_activePrediv;
  logic [RTC_W-1:0] rtcFactor;
  logic [RTC_W-1:0] next_rtcFactor;
  logic [2:0] postDivider;
  logic [2:0] next_postDivider;
  logic [2:0] feedbackMult;
  logic [2:0] next_feedbackMult;
  logic next_pllEnable;
  logic selectPll;
  logic next_selectPll;
  logic lockStale;
  logic next_lockStale;
  logic next_lockLost;
  logic lockFlag;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] wordIdx;
  logic setupPhase;
  logic accessPhase;
  logic supervisor;
  logic hitLp;
  logic hitPre;
  logic hitRtc;
  logic hitCtrl;
  logic hitStat;
  logic errNext;
  logic errFlag;
  logic [31:0] rdNext;
  logic wrAccess;

  assign wordIdx = paddr >> `ADDR_SHIFT;
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign supervisor = pprot[0];
  assign hitLp = (wordIdx == ADDR_W'(`IDX_LOW_POWER_DIV));
  assign hitPre = (wordIdx == ADDR_W'(`IDX_PLL_PREDIV));
  assign hitRtc = (wordIdx == ADDR_W'(`IDX_RTC_DIV));
  assign hitCtrl = (wordIdx == ADDR_W'(`IDX_SYNTH_CTRL));
  assign hitStat = (wordIdx == ADDR_W'(`IDX_SYNTH_STATUS));
  assign lockFlag = pllLockIn && pllEnable && !lockStale;
  assign crystalMode = 1'b1;

  // zero wait states: decode and read data are taken in the setup cycle
  assign pready = 1'b1;
  assign pslverr = accessPhase && errFlag;
  assign wrAccess = accessPhase && pwrite && !errFlag;

  always_comb begin
    errNext = !(hitLp || hitPre || hitRtc || hitCtrl || hitStat);
    if (hitLp && !supervisor) begin
      errNext = 1'b1;
    end
    rdNext = 32'h0000_0000;
    if (!pwrite && !errNext) begin
      if (hitLp) begin
        rdNext[`LPD_MSB:0] = lowPowerExp;
      end
      if (hitPre) begin
        rdNext[`PREDIV_MSB:0] = predivField;
      end
      if (hitRtc) begin
        rdNext[RTC_W-1:0] = rtcFactor;
      end
      if (hitCtrl) begin
        rdNext[`SC_MFD_MSB:`SC_MFD_LSB] = feedbackMult;
        rdNext[`SC_RFD_MSB:`SC_RFD_LSB] = postDivider;
        rdNext[`SC_PLL_EN_BIT] = pllEnable;
        rdNext[`SC_SEL_PLL_BIT] = selectPll;
      end
      if (hitStat) begin
        rdNext[`ST_LOCK_BIT] = lockFlag;
        rdNext[`ST_PLL_ON_BIT] = pllEnable;
        rdNext[`ST_XTAL_BIT] = crystalMode;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      errFlag <= 1'b0;
    end else if (setupPhase) begin
      prdata <= rdNext;
      errFlag <= errNext;
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_comb begin
    next_lowPowerExp = lowPowerExp;
    next_predivField = predivField;
    next_rtcFactor = rtcFactor;
    next_postDivider = postDivider;
    next_feedbackMult = feedbackMult;
    next_pllEnable = pllEnable;
    next_selectPll = selectPll;
    if (wrAccess) begin
      if (hitLp && pstrb[0]) begin
        // upper bits are reserved and dropped
        next_lowPowerExp = pwdata[`LPD_MSB:0];
      end
      if (hitPre && pstrb[0]) begin
        next_predivField = pwdata[`PREDIV_MSB:0];
      end
      if (hitRtc) begin
        for (int b = 0; b < RTC_W / 8; b++) begin
          if (pstrb[b]) begin
            next_rtcFactor[b*8 +: 8] = pwdata[b*8 +: 8];
          end
        end
      end
      if (hitCtrl && pstrb[0]) begin
        next_feedbackMult = pwdata[`SC_MFD_MSB:`SC_MFD_LSB];
        next_postDivider = pwdata[`SC_RFD_MSB:`SC_RFD_LSB];
      end
      if (hitCtrl && pstrb[1]) begin
        next_pllEnable = pwdata[`SC_PLL_EN_BIT];
        next_selectPll = pwdata[`SC_SEL_PLL_BIT];
      end
    end
    // the divider only picks up a new pre-division when the pll comes back on
    next_activePrediv = (next_pllEnable && !pllEnable) ? predivField : activePrediv;
    next_lockLost = (wrAccess && hitPre && pstrb[0]
                     && (pwdata[`PREDIV_MSB:0] != predivField))
                    || (stopMode && pllEnable && !next_pllEnable);
    // a new loss wins over the clear that comes with the lock input dropping
    next_lockStale = next_lockLost || (lockStale && pllLockIn);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lowPowerExp <= `LPD_RST;
      predivField <= `PREDIV_RST;
      activePrediv <= `PREDIV_RST;
      rtcFactor <= RTC_W'(`RTC_RST);
      postDivider <= `RFD_RST;
      feedbackMult <= `MFD_RST;
      pllEnable <= 1'b0;
      selectPll <= 1'b0;
      lockStale <= 1'b0;
      lockLost <= 1'b0;
    end else begin
      lowPowerExp <= next_lowPowerExp;
      predivField <= next_predivField;
      activePrediv <= next_activePrediv;
      rtcFactor <= next_rtcFactor;
      postDivider <= next_postDivider;
      feedbackMult <= next_feedbackMult;
      pllEnable <= next_pllEnable;
      selectPll <= next_selectPll;
      lockStale <= next_lockStale;
      lockLost <= next_lockLost;
    end
  end

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  logic [15:0] lpRatio;
  logic [6:0] fbRatio;
  logic [8:0] postRatio;

  assign systemTick = (selectPll && pllEnable) ? pllSysTick : oscTick;
  assign lpRatio = 16'((32'h0000_0001 << lowPowerExp) - 32'h0000_0001);
  // system multiple is 2*(mult+2), i.e. 4x..18x; the vco runs at 4 << postDivider times the system
  assign fbRatio = 7'(`VCO_PER_SYS * `SYS_MULT_STEP
                      * (int'(feedbackMult) + `MFD_OFFSET) - 1);
  assign postRatio = 9'((`VCO_PER_SYS << postDivider) - 1);

  clk_ratio_divider #(.W(16)) u_lp_div (
    .sys_clk(sys_clk), .srst(srst), .enable(systemTick), .run(1'b1),
    .ratio(lpRatio), .tick(lowPowerTick)
  );

  clk_ratio_divider #(.W(3)) u_pre_div (
    .sys_clk(sys_clk), .srst(srst), .enable(oscTick), .run(pllEnable),
    .ratio(activePrediv), .tick(refTick)
  );

  clk_ratio_divider #(.W(7)) u_fb_div (
    .sys_clk(sys_clk), .srst(srst), .enable(vcoTick), .run(pllEnable),
    .ratio(fbRatio), .tick(fbTick)
  );

  clk_ratio_divider #(.W(9)) u_post_div (
    .sys_clk(sys_clk), .srst(srst), .enable(vcoTick), .run(pllEnable),
    .ratio(postRatio), .tick(pllSysTick)
  );

  // zero factor holds the counter so the rtc sees no tick at all
  clk_ratio_divider #(.W(RTC_W)) u_rtc_div (
    .sys_clk(sys_clk), .srst(srst), .enable(oscTick), .run(rtcFactor != '0),
    .ratio(rtcFactor), .tick(rtcTick)
  );

  // ---------------------------------------------------------------
  // phase-frequency detector and charge pump
  // ---------------------------------------------------------------
  clkgen_pkg::pfd_state_t pfdState;
  clkgen_pkg::pfd_state_t next_pfdState;
  clkgen_pkg::pump_strength_t next_strength;

  // ticks stand for falling edges; edges during the reset cycle are dropped
  always_comb begin
    next_pfdState = pfdState;
    case (pfdState)
      clkgen_pkg::PFD_IDLE: begin
        if (refTick && fbTick) begin
          next_pfdState = clkgen_pkg::PFD_BOTH;
        end else if (refTick) begin
          next_pfdState = clkgen_pkg::PFD_UP;
        end else if (fbTick) begin
          next_pfdState = clkgen_pkg::PFD_DOWN;
        end
      end
      clkgen_pkg::PFD_UP: begin
        if (fbTick) begin
          next_pfdState = clkgen_pkg::PFD_BOTH;
        end
      end
      clkgen_pkg::PFD_DOWN: begin
        if (refTick) begin
          next_pfdState = clkgen_pkg::PFD_BOTH;
        end
      end
      clkgen_pkg::PFD_BOTH: begin
        next_pfdState = clkgen_pkg::PFD_IDLE;
      end
      default: begin
        next_pfdState = clkgen_pkg::PFD_IDLE;
      end
    endcase
    if (!pllEnable) begin
      next_pfdState = clkgen_pkg::PFD_IDLE;
    end
    if (feedbackMult < `MFD_PUMP_2X) begin
      next_strength = clkgen_pkg::PUMP_1X;
    end else if (feedbackMult < `MFD_PUMP_4X) begin
      next_strength = clkgen_pkg::PUMP_2X;
    end else begin
      next_strength = clkgen_pkg::PUMP_4X;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pfdState <= clkgen_pkg::PFD_IDLE;
      pumpStrength <= clkgen_pkg::PUMP_1X;
    end else begin
      pfdState <= next_pfdState;
      pumpStrength <= next_strength;
    end
  end

  assign pumpAdd = pfdState[1] || pfdState[3];
  assign pumpRemove = pfdState[2] || pfdState[3];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_lag_start;
    pllEnable && pfdState == clkgen_pkg::PFD_IDLE && refTick && !fbTick;
  endsequence

  sequence s_lag_close;
    fbTick && pllEnable;
  endsequence

  a_lpd_takes_effect: assert property (@(posedge sys_clk) disable iff (srst)
    (wrAccess && hitLp && pstrb[0]) |=> lowPowerExp == $past(pwdata[`LPD_MSB:0]))
    else $error("low-power exponent not updated after write");

  a_lpd_user_denied: assert property (@(posedge sys_clk) disable iff (srst)
    (accessPhase && hitLp && !supervisor) |-> pslverr ##1 $stable(lowPowerExp))
    else $error("user access reached low-power register");

  a_prediv_on_enable: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(pllEnable) |-> activePrediv == $past(predivField))
    else $error("pre-division not applied on pll enable");

  a_prediv_held: assert property (@(posedge sys_clk) disable iff (srst)
    (pllEnable && $past(pllEnable) && $changed(predivField)) |-> $stable(activePrediv))
    else $error("pre-division changed while pll running");

  a_lost_on_prediv: assert property (@(posedge sys_clk) disable iff (srst)
    (wrAccess && hitPre && pstrb[0] && pwdata[`PREDIV_MSB:0] != predivField)
    |=> lockLost ##1 !lockFlag)
    else $error("pre-division change did not drop lock");

  a_rtc_silent: assert property (@(posedge sys_clk) disable iff (srst)
    (rtcFactor == '0 && $past(rtcFactor) == '0) |-> !rtcTick)
    else $error("rtc tick with zero factor");

  a_rtc_period_two: assert property (@(posedge sys_clk) disable iff (srst)
    (rtcFactor == 1 && $past(rtcFactor, 4) == 1 && rtcTick && $past(oscTick) && oscTick)
    |=> !rtcTick)
    else $error("rtc divide-by-two period wrong");

  a_pfd_lag_up: assert property (@(posedge sys_clk) disable iff (srst)
    s_lag_start ##1 s_lag_close |-> pumpAdd && !pumpRemove ##1 pumpAdd && pumpRemove)
    else $error("pfd lag did not pulse up then reset");

  a_pfd_short_both: assert property (@(posedge sys_clk) disable iff (srst)
    (pllEnable && pfdState == clkgen_pkg::PFD_IDLE && refTick && fbTick)
    |=> (pumpAdd && pumpRemove) ##1 (!pumpAdd && !pumpRemove))
    else $error("aligned edges not one-cycle pulses");

  a_pump_level: assert property (@(posedge sys_clk) disable iff (srst)
    // strength is registered from the previous multiplier, so only a settled multiplier is checked
    $stable(feedbackMult)
    |-> (feedbackMult >= `MFD_PUMP_4X) == (pumpStrength == clkgen_pkg::PUMP_4X))
    else $error("pump strength does not follow multiplier");

  a_reset_pll_off: assert property (@(posedge sys_clk)
    srst |=> !pllEnable && !systemTick == !oscTick && postDivider == `RFD_RST)
    else $error("pll not off after reset");

  a_lock_read: assert property (@(posedge sys_clk) disable iff (srst)
    (setupPhase && hitStat && !pwrite) |=> prdata[0] == $past(lockFlag))
    else $error("status lock bit wrong");

endmodule

// file: pkg/clkgen_regs.svh
// register indices, field positions, reset values and ratio constants of the clock block
// assumes a 32-bit apb slave where the byte address is four times the register index
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

// register indices; byte address is index * 4
`define IDX_LOW_POWER_DIV 24'h12_0007
`define IDX_PLL_PREDIV 24'h12_0008
`define IDX_RTC_DIV 24'h12_0009
`define IDX_SYNTH_CTRL 24'h12_000A
`define IDX_SYNTH_STATUS 24'h12_000B
`define ADDR_SHIFT 2

// field positions
`define LPD_MSB 3
`define PREDIV_MSB 2
`define SC_MFD_LSB 0
`define SC_MFD_MSB 2
`define SC_RFD_LSB 4
`define SC_RFD_MSB 6
`define SC_PLL_EN_BIT 8
`define SC_SEL_PLL_BIT 9
`define ST_LOCK_BIT 0
`define ST_PLL_ON_BIT 1
`define ST_XTAL_BIT 2

// reset values
`define LPD_RST 4'h0
`define PREDIV_RST 3'h0
`define RTC_RST 32'h0000_0000
`define RFD_RST 3'h1
`define MFD_RST 3'h0

// pll ratios
`define VCO_PER_SYS 4
`define SYS_MULT_STEP 2
`define MFD_OFFSET 2
`define MFD_PUMP_2X 3'h2
`define MFD_PUMP_4X 3'h6

`endif

// file: pkg/clkgen_pkg.sv
// types shared by the clock block files
// assumes clkgen_regs.svh supplies the numeric constants
package clkgen_pkg;

  typedef enum logic [3:0] {
    PFD_IDLE = 4'h1,
    PFD_UP = 4'h2,
    PFD_DOWN = 4'h4,
    PFD_BOTH = 4'h8
  } pfd_state_t;

  typedef enum logic [2:0] {
    PUMP_1X = 3'h1,
    PUMP_2X = 3'h2,
    PUMP_4X = 3'h4
  } pump_strength_t;

endpackage

// file: core/clk_ratio_divider.sv
// counting divider that turns an enable stream into a tick every ratio+1 enables
// assumes all rates are enable pulses on sys_clk; srst synchronous active high
`timescale 1ns/100ps
module clk_ratio_divider #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic run,
  input wire logic [W-1:0] ratio,
  output logic tick
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic [W-1:0] curRatio;
  logic [W-1:0] next_curRatio;
  logic next_tick;

  // new ratio is taken at a period boundary or while run is low, so no short period appears
  always_comb begin
    next_count = count;
    next_curRatio = curRatio;
    next_tick = 1'b0;
    if (!run) begin
      next_count = '0;
      next_curRatio = ratio;
    end else if (enable) begin
      if (count == curRatio) begin
        next_count = '0;
        next_curRatio = ratio;
        next_tick = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count <= '0;
      curRatio <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      curRatio <= next_curRatio;
      tick <= next_tick;
    end
  end

endmodule

// file: tb/testbench.sv
// self-checking bench for the clock control block, apb master and tick ratio model
// assumes clkgen_regs.svh indices; pready may wait; ticks are enables on sys_clk
`timescale 1ns/100ps
`include "clkgen_regs.svh"
module testbench;
  localparam logic [23:0] A_LP = `IDX_LOW_POWER_DIV << `ADDR_SHIFT;
  localparam logic [23:0] A_PD = `IDX_PLL_PREDIV << `ADDR_SHIFT;
  localparam logic [23:0] A_RTC = `IDX_RTC_DIV << `ADDR_SHIFT;
  localparam logic [23:0] A_SC = `IDX_SYNTH_CTRL << `ADDR_SHIFT;
  localparam logic [23:0] A_ST = `IDX_SYNTH_STATUS << `ADDR_SHIFT;
  localparam logic [23:0] A_NONE = 24'h48_0040;
  // ----
  // signals
  // ----
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [23:0] paddr = 24'h00_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [2:0] pprot = 3'h0;
  logic oscTick = 1'b0;
  logic vcoTick = 1'b0;
  logic pllLockIn = 1'b0;
  logic stopMode = 1'b0;
  logic [31:0] prdata;
  logic [2:0] pumpStrength;
  logic pready, pslverr, systemTick, lowPowerTick, refTick, fbTick, pllSysTick, rtcTick;
  logic pllEnable, crystalMode, lockLost, pumpAdd, pumpRemove;
  logic sawAdd = 1'b0;
  logic sawRemove = 1'b0;
  int n_errors = 0;
  int n_checks = 0;
  int nLost = 0;
  logic [4:0] outs;
  logic [4:0] ens;
  logic [3:0] probe;
  assign outs = {pllSysTick, fbTick, refTick, rtcTick, lowPowerTick};
  assign ens = {vcoTick, vcoTick, oscTick, oscTick, systemTick};
  assign probe = {systemTick !== oscTick, systemTick !== pllSysTick,
                  (pumpAdd | pumpRemove) !== 1'b0, rtcTick !== 1'b0};

  clock_divider_and_pll_control DUT (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscTick(oscTick),
    .vcoTick(vcoTick), .pllLockIn(pllLockIn), .stopMode(stopMode), .systemTick(systemTick),
    .lowPowerTick(lowPowerTick), .refTick(refTick), .fbTick(fbTick),
    .pllSysTick(pllSysTick), .rtcTick(rtcTick), .pllEnable(pllEnable),
    .crystalMode(crystalMode), .lockLost(lockLost), .pumpAdd(pumpAdd),
    .pumpRemove(pumpRemove), .pumpStrength(pumpStrength));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // random enable streams keep the ratio counts honest against fixed spacing
  always @(posedge sys_clk) begin
    oscTick <= 1'($urandom % 2);
    vcoTick <= ($urandom % 3) != 0;
    if (lockLost === 1'b1) nLost <= nLost + 1;
    if (pumpAdd === 1'b1) sawAdd <= 1'b1;
    if (pumpRemove === 1'b1) sawRemove <= 1'b1;
  end
  // ----
  // tasks
  // ----
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic expire();
    n_errors++;
    $display("[ERR] %0t wait expired got %h exp %h", $time, 1'b0, 1'b1);
    report_and_stop();
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask

  // one idle cycle after each transfer, so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [2:0] p, output logic [31:0] rd, output logic er);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    pprot <= p;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) expire();
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, 4'hF, 3'b001, rd, er);
  endtask

  task automatic rdc(input logic [23:0] a, input logic [31:0] x);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0000_0000, 4'h0, 3'b001, rd, er);
    check(rd, x);
  endtask

  // enables counted between two output pulses; second interval only, as ratios adopt at wrap
  task automatic ratio(input int s, input int x);
    int j;
    int k;
    int n;
    k = 0;
    for (j = 0; j < 2; j++) begin
      n = 0;
      @(negedge sys_clk);
      while (outs[s] !== 1'b1 && k < 4000) begin
        @(negedge sys_clk);
        k++;
      end
      do begin
        n += int'(ens[s] === 1'b1);
        @(negedge sys_clk);
        k++;
      end while (outs[s] !== 1'b1 && k < 8000);
    end
    if (k >= 8000) expire();
    @(posedge sys_clk);
    check(32'(n), 32'(x));
  endtask

  task automatic quiet(input int s);
    int k;
    int n;
    n = 0;
    for (k = 0; k < 300; k++) begin
      @(negedge sys_clk);
      n += int'(probe[s]);
    end
    @(posedge sys_clk);
    check(32'(n), 32'h0000_0000);
  endtask

  task automatic reset_dut();
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rdc(A_LP, 32'h0000_0000);
    rdc(A_PD, 32'h0000_0000);
    rdc(A_RTC, 32'h0000_0000);
    rdc(A_SC, 32'h0000_0010);
    rdc(A_ST, 32'h0000_0004);
    check(pllEnable, 1'b0);
    check(crystalMode, 1'b1);
    check(pumpStrength, 3'b001);
    $display("test reset done");
  endtask
  // ----
  // stimulus
  // ----
  initial begin
    logic [31:0] rd;
    logic er;
    int lpx[4];
    int v, p, q, m, r, base, i;
    lpx = '{0, 1, 3, 7};
    void'($urandom(32'h3781));
    reset_dut();
    apb(1'b1, A_LP, 32'h0000_0003, 4'hF, 3'b000, rd, er);
    check(er, 1'b1);
    rdc(A_LP, 32'h0000_0000);
    apb(1'b0, A_LP, 32'h0000_0000, 4'h0, 3'b000, rd, er);
    check(er, 1'b1);
    wr(A_LP, 32'h0000_000F);
    rdc(A_LP, 32'h0000_000F);
    for (i = 0; i < 4; i++) begin
      wr(A_LP, 32'(lpx[i]));
      rdc(A_LP, 32'(lpx[i]));
      ratio(0, 1 << lpx[i]);
    end
    $display("test low power done");
    v = $urandom_range(20, 1);
    q = $urandom_range(20, 1);
    wr(A_RTC, 32'(v));
    rdc(A_RTC, 32'(v));
    apb(1'b1, A_RTC, 32'hFFFF_FF00 | 32'(q), 4'h1, 3'b001, rd, er);
    rdc(A_RTC, 32'(q));
    ratio(1, q + 1);
    wr(A_RTC, 32'h0000_0000);
    repeat (100) @(posedge sys_clk);
    quiet(0);
    $display("test rtc done");
    quiet(1);
    pllLockIn <= 1'b1;
    wr(A_SC, 32'h0000_0110);
    ratio(4, 8);
    ratio(3, 16);
    quiet(3);
    p = 0;
    for (i = 0; i < 8; i++) begin
      q = (i + 1) % 8;
      base = nLost;
      wr(A_PD, 32'(q));
      repeat (3) @(posedge sys_clk);
      check(32'(nLost - base), 32'h0000_0001);
      ratio(2, p + 1);
      wr(A_SC, 32'h0000_0010);
      wr(A_SC, 32'h0000_0110);
      repeat (3) @(posedge sys_clk);
      check(32'(nLost - base), 32'h0000_0001);
      ratio(2, q + 1);
      p = q;
    end
    stopMode <= 1'b1;
    base = nLost;
    wr(A_SC, 32'h0000_0010);
    repeat (3) @(posedge sys_clk);
    check(32'(nLost - base), 32'h0000_0001);
    stopMode <= 1'b0;
    $display("test prediv done");
    for (m = 0; m < 8; m++) begin
      r = $urandom % 8;
      wr(A_SC, 32'h0000_0100 | 32'(m) | 32'(r << 4));
      ratio(3, 8 * (m + 2));
      ratio(4, 4 << r);
      check(pumpStrength, (m < 2) ? 3'b001 : (m < 6) ? 3'b010 : 3'b100);
    end
    check(sawAdd & sawRemove, 1'b1);
    // three-step change; lock input drops while the loop relocks, which also clears stale lock
    pllLockIn <= 1'b0;
    wr(A_SC, 32'h0000_0127);
    wr(A_SC, 32'h0000_0124);
    pllLockIn <= 1'b1;
    rd = 32'h0000_0000;
    for (i = 0; i < 50 && rd[0] !== 1'b1; i++) begin
      apb(1'b0, A_ST, 32'h0000_0000, 4'h0, 3'b001, rd, er);
    end
    check(rd[0], 1'b1);
    wr(A_SC, 32'h0000_0114);
    ratio(3, 48);
    ratio(4, 8);
    wr(A_SC, 32'h0000_0310);
    quiet(2);
    $display("test synth done");
    pllLockIn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    pllLockIn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdc(A_ST, 32'h0000_0007);
    pllLockIn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    apb(1'b1, A_ST, 32'hFFFF_FFFF, 4'hF, 3'b001, rd, er);
    check(er, 1'b0);
    rdc(A_ST, 32'h0000_0006);
    apb(1'b0, A_NONE, 32'h0000_0000, 4'h0, 3'b001, rd, er);
    check({rd[30:0], er}, 32'h0000_0001);
    $display("test status done");
    reset_dut();
    report_and_stop();
  end
endmodule
